/* pkg/ebs_link_if.sv */
// Carrier between the bus sequencer and its segment port and window decoder
`timescale 1ns/1ps
interface ebs_link_if;
	logic [7:0]                                  seg_dir;
	logic [7:0]                                  seg_data;
	logic [7:0]                                  seg_addr;
	logic [1:0]                                  seg_space;
	logic [7:0]                                  seg_out;
	logic [7:0]                                  seg_oe_b;
	logic [ebs_pkg::NUM_WIN-1:0][ebs_pkg::WIN_W-1:0] win_cfg;
	logic [7:0]                                  win_addr;
	logic [ebs_pkg::NUM_CS-1:0]                  win_sel;
	logic                                        win_hit;
	logic                                        win_rdy;
	logic                                        win_bus8;
	logic                                        win_mux;

	modport seg_top (output seg_dir, seg_data, seg_addr, seg_space, input seg_out, seg_oe_b);
	modport seg_dev (input seg_dir, seg_data, seg_addr, seg_space, output seg_out, seg_oe_b);
	modport win_top (output win_cfg, win_addr, input win_sel, win_hit, win_rdy, win_bus8, win_mux);
	modport win_dev (input win_cfg, win_addr, output win_sel, win_hit, win_rdy, win_bus8, win_mux);
endinterface

/* pkg/ebs_pkg.sv */
// Constants and types shared by the external bus strobe and segment port block
package ebs_pkg;

	// Register byte addresses on the plain register port
	localparam logic [7:0] ADDR_SYSTEM_CONFIG_REG   = 8'h00;
	localparam logic [7:0] ADDR_SEG_DIR  = 8'h04;
	localparam logic [7:0] ADDR_SEG_DATA = 8'h08;
	localparam logic [7:0] ADDR_SEG_PIN  = 8'h0c;
	localparam logic [7:0] ADDR_STATUS   = 8'h10;
	localparam logic [7:0] ADDR_WIN0     = 8'h20;
	localparam logic [7:0] ADDR_WIN_MASK = 8'hf0;
	localparam int         NUM_WIN       = 4;
	localparam int         NUM_CS        = 5;

	// system_config_reg field positions
	localparam int CFG_WRL   = 0;
	localparam int CFG_BUS8  = 1;
	localparam int CFG_MUX   = 2;
	localparam int CFG_RDY   = 3;
	localparam int CFG_SPACE = 4;
	localparam int CFG_W     = 6;
	localparam logic [5:0] SYSTEM_CONFIG_REG_RST = 6'h30;

	// Address window register field positions
	localparam int WIN_BASE = 0;
	localparam int WIN_MASK = 8;
	localparam int WIN_EN   = 16;
	localparam int WIN_RDY  = 17;
	localparam int WIN_BUS8 = 18;
	localparam int WIN_MUX  = 19;
	localparam int WIN_W    = 20;
	localparam logic [19:0] WIN_RST = 20'h00000;

	// Status register field positions
	localparam int STAT_EXT  = 0;
	localparam int STAT_HLDA = 1;
	localparam int STAT_BUSY = 2;

	// External space size codes and matching segment line masks
	localparam logic [1:0] SPACE_64K  = 2'h0;
	localparam logic [1:0] SPACE_256K = 2'h1;
	localparam logic [1:0] SPACE_1M   = 2'h2;
	localparam logic [1:0] SPACE_16M  = 2'h3;
	localparam logic [7:0] LINES_64K  = 8'h00;
	localparam logic [7:0] LINES_256K = 8'h03;
	localparam logic [7:0] LINES_1M   = 8'h0f;
	localparam logic [7:0] LINES_16M  = 8'hff;

	// Segment port reset values: every direction bit input; the 16M reset space still drives all pins as address
	localparam logic [7:0] SEG_DIR_RST  = 8'h00;
	localparam logic [7:0] SEG_DATA_RST = 8'h00;

	// Bus cycle sequencer states
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_STROBE, ST_END, ST_HOLD} ebs_state_t;

endpackage

/* rtl/ebs_seg_port.sv */
// Segment address port: per-pin address, output or input selection
`timescale 1ns/1ps
module ebs_seg_port (
	input  wire logic   clk_in,
	input  wire logic   rst_b_in,
	ebs_link_if.seg_dev lnk
);
	logic [7:0] line_mask;
	logic [7:0] out_r;
	logic [7:0] oe_b_r;

	// Space size decides how many low pins carry address
	assign line_mask = (lnk.seg_space == ebs_pkg::SPACE_16M)  ? ebs_pkg::LINES_16M :
	                   (lnk.seg_space == ebs_pkg::SPACE_1M)   ? ebs_pkg::LINES_1M :
	                   (lnk.seg_space == ebs_pkg::SPACE_256K) ? ebs_pkg::LINES_256K :
	                   ebs_pkg::LINES_64K;

	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_pin
			// RULE1 per-pin direction control
			// RULE15 address lines by space
			always_ff @(posedge clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					out_r[i]  <= 1'b0;
					oe_b_r[i] <= 1'b1;
				end else begin
					out_r[i]  <= line_mask[i] ? lnk.seg_addr[i] : lnk.seg_data[i];
					// RULE2 input pins float unless the space size makes them address lines
					oe_b_r[i] <= !(line_mask[i] || lnk.seg_dir[i]);
				end
			end
		end
	endgenerate

	assign lnk.seg_out  = out_r;
	assign lnk.seg_oe_b = oe_b_r;

	a_seg_input_hiz: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE2
		(lnk.seg_space != ebs_pkg::SPACE_16M && !lnk.seg_dir[7]) |=> lnk.seg_oe_b[7])
		else $error("Segment pin 7 driven while set as input");

	a_seg_lsb_addr: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE3
		(lnk.seg_space != ebs_pkg::SPACE_64K) |=>
		(lnk.seg_out[0] == $past(lnk.seg_addr[0]) && !lnk.seg_oe_b[0]))
		else $error("Segment pin 0 does not carry the lowest segment address line");
endmodule

/* rtl/ebs_top.sv */
// External bus controller: strobes, wait states, address latch, segment port
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: Segment port pins each have direction bit
// RULE2: Input pins leave the driver floating; code drives address-line pins whatever their direction bit
// RULE3: Pin 0 carries A16, pin 7 A23
// RULE4: Read strobe on every read and fetch
// RULE5: Plain mode: write strobe every write
// RULE6: Low-byte mode: 16-bit low writes only
// RULE7: Config bit chooses write strobe mode
// RULE8: Ready high inserts wait states
// RULE9: Address latch enable pulse per access
// RULE10: Fetch select low picks external fetch
// RULE11: Muxed or demuxed, 8 or 16 bits
// RULE12: 16 MByte space, per-range settings
// RULE13: Five chip-select outputs
// RULE14: Hold request answered by hold acknowledge
// RULE15: Space size sets driven segment lines
// RULE16: Demux address on low port, mux shares
// RULE17: Strobes active low, only during access
module ebs_top (
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [31:0] reg_rdata_out,
	input  wire logic        req_in,
	input  wire logic        req_wr_in,
	input  wire logic        req_fetch_in,
	input  wire logic [1:0]  req_be_in,
	input  wire logic [23:0] req_addr_in,
	input  wire logic [15:0] req_wdata_in,
	output logic             ack_out,
	output logic      [15:0] req_rdata_out,
	input  wire logic [7:0]  seg_port_in,
	output logic      [7:0]  seg_port_out,
	output logic      [7:0]  seg_port_oe_b_out,
	input  wire logic [15:0] data_port_in,
	output logic      [15:0] data_port_out,
	output logic      [15:0] data_port_oe_b_out,
	output logic      [15:0] low_addr_port_out,
	output logic             ale_out,
	output logic             rd_n_out,
	output logic             low_byte_write_strobe_n_out,
	input  wire logic        ready_in,
	output logic      [4:0]  cs_n_out,
	input  wire logic        hold_in,
	output logic             hlda_out,
	input  wire logic        ext_fetch_select_n_in
);
	ebs_link_if lnk ();

	logic [1:0]                                      rst_q_r;
	logic                                            rst_b;
	logic [ebs_pkg::CFG_W-1:0]                       system_config_reg_r;
	logic [7:0]                                      seg_dir_r;
	logic [7:0]                                      seg_data_r;
	logic [ebs_pkg::NUM_WIN-1:0][ebs_pkg::WIN_W-1:0] win_r;
	logic                                            ea_done_r;
	logic                                            ext_sel_r;
	ebs_pkg::ebs_state_t                             state_r;
	ebs_pkg::ebs_state_t                             state_nxt;
	logic [23:0]                                     cyc_addr_r;
	logic [15:0]                                     cyc_wdata_r;
	logic [1:0]                                      cyc_be_r;
	logic [4:0]                                      cyc_cs_r;
	logic                                            cyc_wr_r;
	logic                                            cyc_fetch_r;
	logic                                            cyc_ext_r;
	logic                                            cyc_rdy_r;
	logic                                            cyc_bus8_r;
	logic                                            cyc_mux_r;
	logic                                            cyc_wrl_r;
	logic                                            half_r;
	logic [31:0]                                     rdata_r;
	logic                                            ack_r;
	logic [15:0]                                     rdata_cpu_r;
	logic [15:0]                                     data_out_r;
	logic [15:0]                                     data_oe_b_r;
	logic [15:0]                                     low_addr_r;
	logic                                            ale_r;
	logic                                            rd_n_r;
	logic                                            wr_n_r;
	logic [4:0]                                      cs_n_r;
	logic                                            hlda_r;

	// Reset release through two stages; only the second is used
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_q_r <= 2'b00;
		end else begin
			rst_q_r <= {rst_q_r[0], 1'b1};
		end
	end
	assign rst_b = rst_q_r[1];

	// Register write decode
	logic       wr_system_config_reg;
	logic       wr_seg_dir;
	logic       wr_seg_data;
	logic       win_range;
	logic [1:0] win_idx;
	assign wr_system_config_reg   = reg_wr_in && (reg_addr_in == ebs_pkg::ADDR_SYSTEM_CONFIG_REG);
	assign wr_seg_dir  = reg_wr_in && (reg_addr_in == ebs_pkg::ADDR_SEG_DIR);
	assign wr_seg_data = reg_wr_in && (reg_addr_in == ebs_pkg::ADDR_SEG_DATA);
	assign win_range   = ((reg_addr_in & ebs_pkg::ADDR_WIN_MASK) == ebs_pkg::ADDR_WIN0) &&
	                     (reg_addr_in[1:0] == 2'h0);
	assign win_idx     = reg_addr_in[3:2];

	// RULE7 write strobe mode held here
	always_ff @(posedge clk_in or negedge rst_b) begin
		if (!rst_b) begin
			system_config_reg_r <= ebs_pkg::SYSTEM_CONFIG_REG_RST;
			seg_dir_r           <= ebs_pkg::SEG_DIR_RST;
			seg_data_r          <= ebs_pkg::SEG_DATA_RST;
		end else begin
			if (wr_system_config_reg)
				system_config_reg_r <= reg_wdata_in[ebs_pkg::CFG_W-1:0];
			if (wr_seg_dir)
				seg_dir_r <= reg_wdata_in[7:0];
			if (wr_seg_data)
				seg_data_r <= reg_wdata_in[7:0];
		end
	end

	// RULE12 one settings word per window
	genvar w;
	generate
		for (w = 0; w < ebs_pkg::NUM_WIN; w++) begin : g_winreg
			always_ff @(posedge clk_in or negedge rst_b) begin
				if (!rst_b)
					win_r[w] <= ebs_pkg::WIN_RST;
				else if (reg_wr_in && win_range && (win_idx == 2'(w)))
					win_r[w] <= reg_wdata_in[ebs_pkg::WIN_W-1:0];
			end
		end
	endgenerate

	// Register read select; unmapped addresses read zero
	logic [31:0] rd_val;
	logic [31:0] status_val;
	assign status_val = {29'h0, (state_r != ebs_pkg::ST_IDLE), hlda_r, ext_sel_r};
	assign rd_val =
		(reg_addr_in == ebs_pkg::ADDR_SYSTEM_CONFIG_REG)   ? {26'h0, system_config_reg_r} :
		(reg_addr_in == ebs_pkg::ADDR_SEG_DIR)  ? {24'h0, seg_dir_r} :
		(reg_addr_in == ebs_pkg::ADDR_SEG_DATA) ? {24'h0, seg_data_r} :
		(reg_addr_in == ebs_pkg::ADDR_SEG_PIN)  ? {24'h0, seg_port_in} :
		(reg_addr_in == ebs_pkg::ADDR_STATUS)   ? status_val :
		win_range                               ? {12'h0, win_r[win_idx]} : 32'h0;

	// Read data stand in the cycle after the strobe only
	always_ff @(posedge clk_in or negedge rst_b) begin
		if (!rst_b)
			rdata_r <= 32'h0;
		else
			rdata_r <= reg_rd_in ? rd_val : 32'h0;
	end

	// RULE10 fetch source caught just after reset release
	always_ff @(posedge clk_in or negedge rst_b) begin
		if (!rst_b) begin
			ea_done_r <= 1'b0;
			ext_sel_r <= 1'b0;
		end else if (!ea_done_r) begin
			ea_done_r <= 1'b1;
			ext_sel_r <= !ext_fetch_select_n_in;
		end
	end

	// Window decode sees the incoming request address
	assign lnk.win_cfg  = win_r;
	assign lnk.win_addr = req_addr_in[23:16];

	// Request taking; a held request is not retaken while its answer stands
	logic accept;
	logic int_fetch;
	logic split_pend;
	logic wait_req;
	assign accept     = (state_r == ebs_pkg::ST_IDLE) && !hold_in && req_in && !ack_r;
	assign int_fetch  = req_fetch_in && !ext_sel_r;
	// RULE11 word on 8-bit bus takes two cycles
	assign split_pend = cyc_bus8_r && (cyc_be_r == 2'b11) && !half_r;
	// RULE8 ready high holds the strobe phase
	assign wait_req   = cyc_rdy_r && ready_in;

	// Bus cycle sequencer
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ebs_pkg::ST_IDLE: begin
				// RULE14 hold request wins over a new access
				if (hold_in)
					state_nxt = ebs_pkg::ST_HOLD;
				else if (accept)
					state_nxt = int_fetch ? ebs_pkg::ST_END : ebs_pkg::ST_ADDR;
			end
			ebs_pkg::ST_ADDR:   state_nxt = ebs_pkg::ST_STROBE;
			ebs_pkg::ST_STROBE: begin
				if (!wait_req)
					state_nxt = ebs_pkg::ST_END;
			end
			ebs_pkg::ST_END:    state_nxt = (cyc_ext_r && split_pend) ? ebs_pkg::ST_ADDR
			                                                        : ebs_pkg::ST_IDLE;
			ebs_pkg::ST_HOLD: begin
				if (!hold_in)
					state_nxt = ebs_pkg::ST_IDLE;
			end
			default:            state_nxt = ebs_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_b) begin
		if (!rst_b)
			state_r <= ebs_pkg::ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// Cycle settings except the segment space are frozen at acceptance, so writes to them cannot tear a cycle
	always_ff @(posedge clk_in or negedge rst_b) begin
		if (!rst_b) begin
			cyc_addr_r  <= 24'h0;
			cyc_wdata_r <= 16'h0;
			cyc_be_r    <= 2'h0;
			cyc_cs_r    <= 5'h0;
			{cyc_wr_r, cyc_fetch_r, cyc_ext_r, cyc_rdy_r} <= 4'h0;
			{cyc_bus8_r, cyc_mux_r, cyc_wrl_r, half_r}    <= 4'h0;
		end else if (accept) begin
			cyc_addr_r  <= req_addr_in;
			cyc_wdata_r <= req_wdata_in;
			cyc_be_r    <= req_be_in;
			cyc_cs_r    <= lnk.win_sel;
			cyc_wr_r    <= req_wr_in && !req_fetch_in;
			cyc_fetch_r <= req_fetch_in;
			cyc_ext_r   <= !int_fetch;
			cyc_rdy_r   <= lnk.win_hit ? lnk.win_rdy : system_config_reg_r[ebs_pkg::CFG_RDY];
			cyc_bus8_r  <= lnk.win_hit ? lnk.win_bus8 : system_config_reg_r[ebs_pkg::CFG_BUS8];
			cyc_mux_r   <= lnk.win_hit ? lnk.win_mux : system_config_reg_r[ebs_pkg::CFG_MUX];
			cyc_wrl_r   <= system_config_reg_r[ebs_pkg::CFG_WRL];
			half_r      <= 1'b0;
		end else if (state_r == ebs_pkg::ST_END && split_pend) begin
			half_r <= 1'b1;
		end
	end

	// Byte lane and bus address of the current transfer
	logic        byte_hi;
	logic [23:0] bus_addr;
	logic [15:0] bus_wdata;
	logic        wr_pin_en;
	logic        drive_data;
	assign byte_hi    = cyc_bus8_r && (half_r || cyc_be_r == 2'b10);
	assign bus_addr   = cyc_bus8_r ? {cyc_addr_r[23:1], byte_hi} : cyc_addr_r;
	assign bus_wdata  = cyc_bus8_r ? {8'h0, (byte_hi ? cyc_wdata_r[15:8] : cyc_wdata_r[7:0])}
	                               : cyc_wdata_r;
	// RULE6 low-byte mode skips high-only writes on 16-bit bus
	assign wr_pin_en  = !cyc_wrl_r || cyc_bus8_r || cyc_be_r[0];
	// RULE16 muxed address rides the data port
	assign drive_data = (state_r == ebs_pkg::ST_ADDR && cyc_mux_r) ||
	                    (state_r == ebs_pkg::ST_STROBE && cyc_wr_r) ||
	                    (state_r == ebs_pkg::ST_END && cyc_ext_r && cyc_wr_r);

	// RULE3 top address byte feeds the segment port
	assign lnk.seg_dir   = seg_dir_r;
	assign lnk.seg_data  = seg_data_r;
	assign lnk.seg_addr  = bus_addr[23:16];
	assign lnk.seg_space = system_config_reg_r[ebs_pkg::CFG_SPACE +: 2];

	// Pins follow the sequencer one cycle later, so each stands clean of decode glitches
	always_ff @(posedge clk_in or negedge rst_b) begin
		if (!rst_b) begin
			ale_r       <= 1'b0;
			rd_n_r      <= 1'b1;
			wr_n_r      <= 1'b1;
			cs_n_r      <= 5'h1f;
			hlda_r      <= 1'b0;
			data_out_r  <= 16'h0;
			data_oe_b_r <= 16'hffff;
			low_addr_r  <= 16'h0;
		end else begin
			// RULE9 one latch pulse per bus cycle
			ale_r       <= (state_r == ebs_pkg::ST_ADDR);
			// RULE4 read strobe for fetch and data
			rd_n_r      <= !(state_r == ebs_pkg::ST_STROBE && !cyc_wr_r);
			// RULE5 plain mode strobes every write
			wr_n_r      <= !(state_r == ebs_pkg::ST_STROBE && cyc_wr_r && wr_pin_en);
			// RULE13 select held through the access
			cs_n_r      <= (state_r == ebs_pkg::ST_ADDR || state_r == ebs_pkg::ST_STROBE) ?
			               ~cyc_cs_r : 5'h1f;
			// RULE14 acknowledge while bus is given away
			hlda_r      <= (state_r == ebs_pkg::ST_HOLD);
			data_out_r  <= (state_r == ebs_pkg::ST_ADDR) ? bus_addr[15:0] : bus_wdata;
			data_oe_b_r <= !drive_data ? 16'hffff :
			               (cyc_bus8_r && state_r != ebs_pkg::ST_ADDR) ? 16'hff00 : 16'h0000;
			if (state_r == ebs_pkg::ST_ADDR && !cyc_mux_r)
				low_addr_r <= bus_addr[15:0];
		end
	end

	// Read data taken at the end phase while the read strobe is still low
	always_ff @(posedge clk_in or negedge rst_b) begin
		if (!rst_b) begin
			ack_r       <= 1'b0;
			rdata_cpu_r <= 16'h0;
		end else begin
			ack_r <= (state_r == ebs_pkg::ST_END) && !(cyc_ext_r && split_pend);
			if (state_r == ebs_pkg::ST_IDLE && accept)
				rdata_cpu_r <= 16'h0;
			else if (state_r == ebs_pkg::ST_END && cyc_ext_r && !cyc_wr_r) begin
				if (!cyc_bus8_r)
					rdata_cpu_r <= data_port_in;
				else if (byte_hi)
					rdata_cpu_r[15:8] <= data_port_in[7:0];
				else
					rdata_cpu_r[7:0] <= data_port_in[7:0];
			end
		end
	end

	ebs_seg_port u_seg (
		.clk_in   (clk_in),
		.rst_b_in (rst_b),
		.lnk      (lnk.seg_dev)
	);

	ebs_win_dec u_win (
		.clk_in   (clk_in),
		.rst_b_in (rst_b),
		.lnk      (lnk.win_dev)
	);

	assign reg_rdata_out               = rdata_r;
	assign ack_out                     = ack_r;
	assign req_rdata_out               = rdata_cpu_r;
	assign seg_port_out                = lnk.seg_out;
	assign seg_port_oe_b_out           = lnk.seg_oe_b;
	assign data_port_out               = data_out_r;
	assign data_port_oe_b_out          = data_oe_b_r;
	assign low_addr_port_out           = low_addr_r;
	assign ale_out                     = ale_r;
	assign rd_n_out                    = rd_n_r;
	assign low_byte_write_strobe_n_out = wr_n_r;
	assign cs_n_out                    = cs_n_r;
	assign hlda_out                    = hlda_r;

	a_rd_for_reads: assert property (@(posedge clk_in) disable iff (!rst_b) // RULE4
		(state_r == ebs_pkg::ST_STROBE && !cyc_wr_r) |=> (!rd_n_r && wr_n_r))
		else $error("Read access without read strobe");

	a_wr_plain_mode: assert property (@(posedge clk_in) disable iff (!rst_b) // RULE5
		(state_r == ebs_pkg::ST_STROBE && cyc_wr_r && !cyc_wrl_r) |=> (!wr_n_r && rd_n_r))
		else $error("Plain mode write without write strobe");

	a_wrl_high_only: assert property (@(posedge clk_in) disable iff (!rst_b) // RULE6
		(state_r == ebs_pkg::ST_STROBE && cyc_wr_r && cyc_wrl_r && !cyc_bus8_r && !cyc_be_r[0])
		|=> wr_n_r)
		else $error("Low-byte mode strobed a high-byte-only write");

	a_wrl_mode_latch: assert property (@(posedge clk_in) disable iff (!rst_b) // RULE7
		accept |=> (cyc_wrl_r == $past(system_config_reg_r[ebs_pkg::CFG_WRL])))
		else $error("Write strobe mode not taken from config bit");

	a_ready_wait: assert property (@(posedge clk_in) disable iff (!rst_b) // RULE8
		(state_r == ebs_pkg::ST_STROBE && cyc_rdy_r && ready_in) |=>
		(state_r == ebs_pkg::ST_STROBE) ##1 (cyc_wr_r ? !wr_n_r || !wr_pin_en : !rd_n_r))
		else $error("Ready high did not extend the strobe");

	a_ale_one_pulse: assert property (@(posedge clk_in) disable iff (!rst_b) // RULE9
		(accept && !int_fetch) |=> ##1 ale_r ##1 !ale_r)
		else $error("Address latch pulse missing or too long");

	a_int_fetch_quiet: assert property (@(posedge clk_in) disable iff (!rst_b) // RULE10
		(accept && req_fetch_in && !ext_sel_r) |=> (rd_n_r && !ale_r) [*2] ##0 ack_r)
		else $error("Internal fetch touched the external bus");

	a_hold_release: assert property (@(posedge clk_in) disable iff (!rst_b) // RULE14
		hlda_r |-> (rd_n_r && wr_n_r && (&data_oe_b_r) && (&cs_n_r)))
		else $error("Bus driven while hold acknowledged");

	a_strobe_idle: assert property (@(posedge clk_in) disable iff (!rst_b) // RULE17
		($past(state_r) == ebs_pkg::ST_IDLE) |-> (rd_n_r && wr_n_r))
		else $error("Strobe active outside an access");
endmodule

/* rtl/ebs_win_dec.sv */
// Address window decoder: chip-select choice and per-range bus settings
`timescale 1ns/1ps
module ebs_win_dec (
	input  wire logic   clk_in,
	input  wire logic   rst_b_in,
	ebs_link_if.win_dev lnk
);
	logic [ebs_pkg::NUM_WIN-1:0] hit;
	logic [ebs_pkg::NUM_WIN-1:0] win_mask;
	logic [1:0]                  top_idx;

	genvar i;
	generate
		for (i = 0; i < ebs_pkg::NUM_WIN; i++) begin : g_win
			// RULE12 range compare on top address byte
			assign win_mask[i] = lnk.win_cfg[i][ebs_pkg::WIN_EN];
			assign hit[i] = win_mask[i] &&
				((lnk.win_addr & lnk.win_cfg[i][ebs_pkg::WIN_MASK +: 8]) ==
				 (lnk.win_cfg[i][ebs_pkg::WIN_BASE +: 8] & lnk.win_cfg[i][ebs_pkg::WIN_MASK +: 8]));
		end
	endgenerate

	// Higher window wins, so overlaps resolve without software care
	assign top_idx = hit[3] ? 2'h3 : hit[2] ? 2'h2 : hit[1] ? 2'h1 : 2'h0;
	assign lnk.win_hit  = |hit;
	// RULE13 one of five selects
	assign lnk.win_sel  = lnk.win_hit ? (5'h02 << top_idx) : 5'h01;
	assign lnk.win_rdy  = lnk.win_cfg[top_idx][ebs_pkg::WIN_RDY];
	assign lnk.win_bus8 = lnk.win_cfg[top_idx][ebs_pkg::WIN_BUS8];
	assign lnk.win_mux  = lnk.win_cfg[top_idx][ebs_pkg::WIN_MUX];

	a_cs_one_select: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE13
		$onehot(lnk.win_sel) && (lnk.win_sel[0] == !(|hit)))
		else $error("Chip-select choice is not exactly one");
endmodule

/* sim/ebs_mem_model.sv */
// External memory stand-in: fixed read word and ready wait states
`timescale 1ns/1ps
module ebs_mem_model (
	input  wire logic        clk_in,
	input  wire logic        rd_n_in,
	input  wire logic        ale_in,
	input  wire logic [3:0]  waits_in,
	output logic      [15:0] data_out,
	output logic             ready_out
);
	logic [3:0] cnt_r = 4'h0;
	// ready high for the set waits
	always_ff @(posedge clk_in) begin
		cnt_r <= ale_in ? ((waits_in != 4'h0) ? waits_in - 4'h1 : 4'h0) :
			((cnt_r != 4'h0) ? cnt_r - 4'h1 : 4'h0);
	end
	assign ready_out = ale_in ? (waits_in != 4'h0) : (cnt_r != 4'h0);
	// Released bus shows the inverse word, so stale data cannot pass
	assign data_out = rd_n_in ? 16'h3c5a : 16'hc3a5;
endmodule

/* sim/external_bus_strobes_seg_addr_tb.sv */
// Self-checking bench for the external bus strobe and segment port block
`timescale 1ns/1ps
module external_bus_strobes_seg_addr_tb;
	logic        clk_in = 1'b0;
	logic        rst_b_in = 1'b0;
	logic [7:0]  ra = 8'h00;
	logic [31:0] rw = 32'h0;
	logic [31:0] rdat;
	logic        rwr = 1'b0;
	logic        rrd = 1'b0;
	logic        req = 1'b0;
	logic        wr = 1'b0;
	logic        fe = 1'b0;
	logic        ack, rdn, wrn, ale, rdy;
	logic [1:0]  be = 2'h3;
	logic [15:0] rq_d, dpi;
	logic [7:0]  spo, spoe;
	logic [3:0]  waits = 4'h0;
	logic [4:0]  cs, cs_seen;
	logic        hold = 1'b0;
	logic        eas = 1'b0;
	logic        hlda;
	int          failures = 0;
	int          checked = 0;
	int          n_rd, n_wr, n_ale, n_cyc, c0;
	// Clock at 50 MHz
	always #10 clk_in = ~clk_in;
	ebs_top uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(ra), .reg_wdata_in(rw),
		.reg_wr_in(rwr), .reg_rd_in(rrd), .reg_rdata_out(rdat), .req_in(req),
		.req_wr_in(wr), .req_fetch_in(fe), .req_be_in(be), .req_addr_in(24'h5a1234),
		.req_wdata_in(16'h6b7c), .ack_out(ack), .req_rdata_out(rq_d),
		.seg_port_in(8'h3c), .seg_port_out(spo), .seg_port_oe_b_out(spoe),
		.data_port_in(dpi), .data_port_out(), .data_port_oe_b_out(), .low_addr_port_out(),
		.ale_out(ale), .rd_n_out(rdn), .low_byte_write_strobe_n_out(wrn), .ready_in(rdy),
		.cs_n_out(cs), .hold_in(hold), .hlda_out(hlda), .ext_fetch_select_n_in(eas));
	ebs_mem_model mem (.clk_in(clk_in), .rd_n_in(rdn), .ale_in(ale), .waits_in(waits),
		.data_out(dpi), .ready_out(rdy));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		ra <= a;
		rw <= d;
		rwr <= 1'b1;
		@(posedge clk_in);
		rwr <= 1'b0;
	endtask
	// Runs one access, counting strobe and latch cycles until ack
	task automatic acc(input logic w, input logic f, input logic [1:0] b);
		wr <= w;
		fe <= f;
		be <= b;
		req <= 1'b1;
		{n_rd, n_wr, n_ale, n_cyc} = '0;
		cs_seen = 5'h1f;
		do begin
			@(posedge clk_in);
			#1;
			if (cs != 5'h1f)
				cs_seen = cs;
			n_rd += !rdn;
			n_wr += !wrn;
			n_ale += ale;
			n_cyc++;
		end while (ack !== 1'b1 && n_cyc < 40);
		req <= 1'b0;
		chk(ack, 1'b1);
		@(posedge clk_in);
		#1 chk({rdn, wrn}, 2'h3);
	endtask
	task automatic t_seg();
		wreg(ebs_pkg::ADDR_SYSTEM_CONFIG_REG, 32'h0);
		wreg(ebs_pkg::ADDR_SEG_DIR, 32'h0f);
		wreg(ebs_pkg::ADDR_SEG_DATA, 32'ha5);
		rrd <= 1'b1;
		ra <= ebs_pkg::ADDR_SEG_PIN;
		@(posedge clk_in);
		rrd <= 1'b0;
		#1 chk(rdat, 32'h3c);
		chk({spoe, spo[3:0]}, 12'hf05);
		wreg(ebs_pkg::ADDR_SYSTEM_CONFIG_REG, 32'h20);
		acc(1'b0, 1'b0, 2'h3);
		chk({spoe, spo[3:0]}, 12'hf0a);
		wreg(ebs_pkg::ADDR_SYSTEM_CONFIG_REG, 32'h30);
		acc(1'b0, 1'b0, 2'h3);
		chk({spoe, spo}, 16'h005a);
	endtask
	task automatic t_rd();
		wreg(ebs_pkg::ADDR_SYSTEM_CONFIG_REG, 32'h38);
		acc(1'b0, 1'b1, 2'h3);
		chk({rq_d, 1'b0 + (n_rd > 0), n_ale[1:0]}, 19'h61d2d);
		chk(cs_seen, 5'h1e);
		c0 = n_cyc;
		waits <= 4'h3;
		acc(1'b0, 1'b0, 2'h3);
		chk(n_cyc > c0, 1'b1);
		wreg(ebs_pkg::ADDR_SYSTEM_CONFIG_REG, 32'h30);
		acc(1'b0, 1'b0, 2'h3);
		chk(n_cyc, c0);
	endtask
	// Write strobe per mode, width and byte lane
	task automatic t_wr();
		for (int i = 1; i < 4; i++) begin
			acc(1'b1, 1'b0, i[1:0]);
			chk(n_wr > 0, 1'b1);
		end
		wreg(ebs_pkg::ADDR_SYSTEM_CONFIG_REG, 32'h31);
		acc(1'b1, 1'b0, 2'h2);
		chk(n_wr, 0);
		acc(1'b1, 1'b0, 2'h1);
		chk(n_wr > 0, 1'b1);
		wreg(ebs_pkg::ADDR_SYSTEM_CONFIG_REG, 32'h33);
		acc(1'b1, 1'b0, 2'h2);
		chk({n_wr > 0, n_rd}, 33'h100000000);
	endtask
	// Window 0 covers segment 5a and takes the first window select
	task automatic t_win();
		wreg(ebs_pkg::ADDR_WIN0, 32'h1ff5a);
		acc(1'b0, 1'b0, 2'h3);
		chk(cs_seen, 5'h1d);
	endtask
	// Hold request gives the bus away and takes it back
	task automatic t_hold();
		@(posedge clk_in);
		hold <= 1'b1;
		repeat (3) @(posedge clk_in);
		chk(hlda, 1'b1);
		hold <= 1'b0;
		repeat (3) @(posedge clk_in);
		chk(hlda, 1'b0);
	endtask
	// Second reset with fetch select high: fetches stay internal
	task automatic t_ea();
		eas <= 1'b1;
		rst_b_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rst_b_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		acc(1'b0, 1'b1, 2'h3);
		chk({n_rd, n_ale}, 64'h0);
		chk(rq_d, 16'h0);
	endtask
	task automatic print_verdict();
		$display("failures=%0d checked=%0d", failures, checked);
		if (failures == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Main sequence after a six cycle reset
	initial begin
		repeat (6) @(posedge clk_in);
		rst_b_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		t_seg();
		t_rd();
		t_wr();
		t_win();
		t_hold();
		t_ea();
		print_verdict();
	end
	// Watchdog well past the expected run
	initial begin
		repeat (5000) @(posedge clk_in);
		failures++;
		print_verdict();
	end
endmodule
